//--- rtl/pmcs_consts.svh
/*
 * Constants of the power-mode clock sequencer: reset values and timing counts.
 * Assumes a 100 MHz system clock; included by every design file of the block except the clock gate.
 */
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH

// Regulator control register: bit 0 is the regulator-on bit, reset value on.
`define PMCS_VRCTL_W 8
`define PMCS_VRCTL_ON_BIT 0
`define PMCS_VRCTL_RST 8'h01

// Minimum GPIO wake pulse and its cycle count at 100 MHz (rounded up, at least one).
`define PMCS_CLK_PERIOD_NS 10
`define PMCS_WAKE_MIN_NS 10
`define PMCS_WAKE_MIN_CYC (((`PMCS_WAKE_MIN_NS) + (`PMCS_CLK_PERIOD_NS) - 1) / (`PMCS_CLK_PERIOD_NS))

// Cycles of boot sequence after power good before leaving boot.
`define PMCS_BOOT_CYC 16
`define PMCS_CNT_W 5

`endif

//--- rtl/pmcs_pkg.sv
/*
 * Types of the power-mode clock sequencer.
 * Assumes the constants header is included before it is compiled.
 */
`include "pmcs_consts.svh"

package pmcs_pkg;

    typedef enum logic [1:0] {
        PMCS_REQ_ACTIVE,
        PMCS_REQ_SLEEP,
        PMCS_REQ_DEEP,
        PMCS_REQ_HIBERNATE
    } pmcs_req_t;

    typedef enum logic [2:0] {
        PMCS_ST_BOOT,
        PMCS_ST_FULL_ON,
        PMCS_ST_ACTIVE,
        PMCS_ST_SLEEP,
        PMCS_ST_DEEP,
        PMCS_ST_HIBERNATE
    } pmcs_state_t;

    // Clock and power controls presented to the clock tree and the pads.
    typedef struct packed {
        logic core_clk_en;
        logic sys_clk_en;
        logic pll_en;
        logic pll_bypass;
        logic dma_l1_grant_en;
        logic async_access_en;
        logic pads_hiz;
        logic regs_valid;
    } pmcs_ctrl_t;

    // Software command from the core.
    typedef struct packed {
        logic go;
        pmcs_req_t mode;
        logic vrctl_we;
        logic [`PMCS_VRCTL_W-1:0] vrctl_data;
    } pmcs_cmd_t;

endpackage

//--- rtl/pmcs_clk_gate.sv
/*
 * Glitch-free clock gate: enable latched while the clock is low.
 * Assumes the enable is launched from flops on the rising edge of the same clock.
 */
`timescale 1ns/1ps

module pmcs_clk_gate (
    // Clock in and gated clock out.
    input wire logic clk_i,
    output logic gclk_o,
    // Gate control.
    input wire logic en_i
);

    logic en_lat;

    // Latch is transparent only while the clock is low, so the gate never chops a high phase.
    always_latch begin
        if (!clk_i) begin
            en_lat <= en_i;
        end
    end

    assign gclk_o = clk_i & en_lat;

endmodule

//--- rtl/pmcs_wake_det.sv
/*
 * GPIO wake detector: a level held for the minimum pulse time raises a wake pulse.
 * Assumes the wake pin is synchronous to the system clock.
 */
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module pmcs_wake_det (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Wake level in, wake pulse out.
    input wire logic level_i,
    output logic wake_o
);

    typedef struct packed {
        logic [3:0] cnt;
        logic wake;
    } pmcs_wd_state_t;

    pmcs_wd_state_t st;
    pmcs_wd_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.wake = 1'b0;
        if (!level_i) begin
            next_st.cnt = 4'h0;
        end else if (st.cnt < 4'(`PMCS_WAKE_MIN_CYC)) begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'(`PMCS_WAKE_MIN_CYC - 1)) begin
                next_st.wake = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wake_o = st.wake;

    a_wake_after_level: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        wake_o |-> $past(level_i))
        else $error("Wake pulse without a held wake level.");

endmodule

//--- rtl/pmcs_sequencer.sv
/*
 * Power-mode clock sequencer: mode state machine, clock gates, regulator wake
 * output, retained regulator control register and power-good start gating.
 * Assumes the core drives mode commands synchronously, and that the retention
 * domain (regulator control register) is reset only by the power-on reset.
 */
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module pmcs_sequencer
    import pmcs_pkg::*;
(
    // Clock and resets.
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic por_rst_i,
    // Clock sources.
    input wire logic input_clock_pin_i,
    input wire logic pll_clk_i,
    // Gated clocks.
    output logic core_clock_o,
    output logic sys_clock_o,
    // Software command.
    input wire pmcs_cmd_t cmd_i,
    // Wake sources and supply status.
    input wire logic regulator_wake_out_event_i,
    input wire logic gpio_wake_i,
    input wire logic power_good_in_n_i,
    // Regulator interface.
    output logic regulator_wake_out_o,
    // DMA request into level-one memory.
    input wire logic dma_l1_req_i,
    output logic dma_l1_gnt_o,
    input wire logic l1_dma_cfg_i,
    // Asynchronous peripheral access request.
    input wire logic async_req_i,
    output logic async_gnt_o,
    // Status.
    output pmcs_ctrl_t ctrl_o,
    output pmcs_state_t state_o,
    output logic [`PMCS_VRCTL_W-1:0] vrctl_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        pmcs_state_t mode;
        logic [`PMCS_CNT_W-1:0] boot_cnt;
        pmcs_ctrl_t ctrl;
        logic dma_gnt;
        logic async_gnt;
    } pmcs_seq_state_t;

    pmcs_seq_state_t st;
    pmcs_seq_state_t next_st;

    // Retention domain, kept apart so that system reset only sets its regulator-on bit.
    logic [`PMCS_VRCTL_W-1:0] vrctl;
    logic [`PMCS_VRCTL_W-1:0] next_vrctl;

    logic gpio_wake;
    logic pg_ok;

    assign pg_ok = ~power_good_in_n_i;

    ////////////////////////////////////////////////////////////////////////////
    // GPIO wake detection.

    pmcs_wake_det u_wake (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .level_i(gpio_wake_i),
        .wake_o(gpio_wake)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Regulator control register.

    always_comb begin
        next_vrctl = vrctl;
        if (cmd_i.vrctl_we) begin
            next_vrctl = cmd_i.vrctl_data;
        end
        // The mode flops are already cleared by the reset, so any reset asks for core power.
        if (sys_rst_i) begin
            next_vrctl[`PMCS_VRCTL_ON_BIT] = 1'b1;
        end
    end

    // Only power-on reset loads its reset value; hibernate keeps it while the I/O supply holds.
    always_ff @(posedge clk_sys_i or posedge por_rst_i) begin
        if (por_rst_i) begin
            vrctl <= `PMCS_VRCTL_RST;
        end else begin
            vrctl <= next_vrctl;
        end
    end

    // High asks for core power, low asks the regulator to shut down.
    assign regulator_wake_out_o = vrctl[`PMCS_VRCTL_ON_BIT];
    assign vrctl_o = vrctl;

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine.

    always_comb begin
        next_st = st;
        next_st.dma_gnt = 1'b0;
        next_st.async_gnt = 1'b0;
        case (st.mode)
            PMCS_ST_BOOT: begin
                // Hold off until power good, then count out the boot sequence.
                if (!pg_ok) begin
                    next_st.boot_cnt = '0;
                end else if (st.boot_cnt == `PMCS_CNT_W'(`PMCS_BOOT_CYC - 1)) begin
                    next_st.mode = PMCS_ST_FULL_ON;
                end else begin
                    next_st.boot_cnt = st.boot_cnt + `PMCS_CNT_W'(1);
                end
            end
            PMCS_ST_FULL_ON, PMCS_ST_ACTIVE: begin
                if (cmd_i.go) begin
                    case (cmd_i.mode)
                        PMCS_REQ_ACTIVE: next_st.mode = PMCS_ST_ACTIVE;
                        PMCS_REQ_SLEEP: next_st.mode = PMCS_ST_SLEEP;
                        PMCS_REQ_DEEP: next_st.mode = PMCS_ST_DEEP;
                        PMCS_REQ_HIBERNATE: next_st.mode = PMCS_ST_HIBERNATE;
                        default: next_st.mode = st.mode;
                    endcase
                end
            end
            PMCS_ST_SLEEP: begin
                if (regulator_wake_out_event_i || gpio_wake) begin
                    next_st.mode = PMCS_ST_FULL_ON;
                end
            end
            PMCS_ST_DEEP: begin
                // Only a GPIO wake leaves here; reset is handled by the flop reset.
                if (gpio_wake) begin
                    next_st.mode = PMCS_ST_FULL_ON;
                end
            end
            PMCS_ST_HIBERNATE: begin
                next_st.mode = PMCS_ST_HIBERNATE;
            end
            default: begin
                next_st.mode = PMCS_ST_BOOT;
            end
        endcase

        // Controls follow the next mode, so the gate enables change with the mode.
        next_st.ctrl = '0;
        next_st.ctrl.regs_valid = 1'b1;
        next_st.ctrl.pll_en = 1'b1;
        case (next_st.mode)
            PMCS_ST_BOOT: begin
                next_st.ctrl.sys_clk_en = pg_ok;
            end
            PMCS_ST_FULL_ON: begin
                next_st.ctrl.core_clk_en = 1'b1;
                next_st.ctrl.sys_clk_en = 1'b1;
                next_st.ctrl.dma_l1_grant_en = 1'b1;
                next_st.ctrl.async_access_en = 1'b1;
            end
            PMCS_ST_ACTIVE: begin
                next_st.ctrl.pll_bypass = 1'b1;
                next_st.ctrl.core_clk_en = 1'b1;
                next_st.ctrl.sys_clk_en = 1'b1;
                next_st.ctrl.dma_l1_grant_en = 1'b1;
                next_st.ctrl.async_access_en = 1'b1;
            end
            PMCS_ST_SLEEP: begin
                next_st.ctrl.sys_clk_en = 1'b1;
                next_st.ctrl.async_access_en = 1'b1;
            end
            PMCS_ST_DEEP: begin
                next_st.ctrl.pll_en = 1'b0;
            end
            PMCS_ST_HIBERNATE: begin
                next_st.ctrl.pll_en = 1'b0;
                next_st.ctrl.pads_hiz = 1'b1;
                next_st.ctrl.regs_valid = 1'b0;
            end
            default: begin
                next_st.ctrl.pll_en = 1'b1;
            end
        endcase

        next_st.dma_gnt = dma_l1_req_i & l1_dma_cfg_i & st.ctrl.dma_l1_grant_en;
        next_st.async_gnt = async_req_i & st.ctrl.async_access_en;
    end

    // System reset restarts through boot from every mode, hibernate included.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock selection and gating.

    logic root_clk;

    // Bypass routes the input pin straight to both derived clocks.
    assign root_clk = st.ctrl.pll_bypass ? input_clock_pin_i : pll_clk_i;

    pmcs_clk_gate u_core_gate (
        .clk_i(root_clk),
        .gclk_o(core_clock_o),
        .en_i(st.ctrl.core_clk_en)
    );

    pmcs_clk_gate u_sys_gate (
        .clk_i(root_clk),
        .gclk_o(sys_clock_o),
        .en_i(st.ctrl.sys_clk_en)
    );

    assign dma_l1_gnt_o = st.dma_gnt;
    assign async_gnt_o = st.async_gnt;
    assign ctrl_o = st.ctrl;
    assign state_o = st.mode;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_pg_held;
        pg_ok [*2];
    endsequence

    a_boot_needs_pg: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ($past(st.mode) == PMCS_ST_BOOT && st.mode == PMCS_ST_FULL_ON) |-> $past(pg_ok))
        else $error("Left boot without power good.");

    a_boot_progress: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (st.mode == PMCS_ST_BOOT && st.boot_cnt == '0) ##0 s_pg_held
        |-> ##[1:20] st.mode == PMCS_ST_FULL_ON or !pg_ok)
        else $error("Boot did not complete.");

    a_full_on_ctrl: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_FULL_ON |-> st.ctrl.pll_en && !st.ctrl.pll_bypass
        && st.ctrl.core_clk_en && st.ctrl.sys_clk_en)
        else $error("Full-on controls wrong.");

    a_active_bypass: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_ACTIVE |-> st.ctrl.pll_bypass && st.ctrl.pll_en)
        else $error("Active mode not bypassing PLL.");

    a_sleep_clocks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_SLEEP |-> !st.ctrl.core_clk_en && st.ctrl.sys_clk_en)
        else $error("Sleep clock enables wrong.");

    a_sleep_no_dma: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $past(st.mode) == PMCS_ST_SLEEP |-> !dma_l1_gnt_o)
        else $error("DMA granted in sleep.");

    a_deep_exit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ($past(st.mode) == PMCS_ST_DEEP && st.mode != PMCS_ST_DEEP) |-> $past(gpio_wake))
        else $error("Deep sleep left without a wake.");

    a_deep_no_async: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $past(st.mode) == PMCS_ST_DEEP |-> !async_gnt_o)
        else $error("Async access granted in deep sleep.");

    a_hib_pads: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_HIBERNATE |-> st.ctrl.pads_hiz && !st.ctrl.sys_clk_en)
        else $error("Hibernate pads or clocks wrong.");

    a_vrctl_write: assert property (@(posedge clk_sys_i)
        disable iff (por_rst_i || sys_rst_i)
        cmd_i.vrctl_we && !cmd_i.vrctl_data[`PMCS_VRCTL_ON_BIT] |=> !regulator_wake_out_o)
        else $error("Regulator wake not low after shutdown write.");

    ////////////////////////////////////////////////////////////////////////////
    // Checks of the clock enables, the grants, the pads, the mode exits and the retained register.

    a_active_clocks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_ACTIVE |-> st.ctrl.core_clk_en && st.ctrl.sys_clk_en)
        else $error("Active mode clock enables wrong.");

    a_active_dma_en: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_ACTIVE |-> st.ctrl.dma_l1_grant_en)
        else $error("Active mode does not allow level-one DMA.");

    a_active_dma: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $past(st.mode == PMCS_ST_ACTIVE && dma_l1_req_i && l1_dma_cfg_i) |-> dma_l1_gnt_o)
        else $error("Configured DMA refused in active mode.");

    a_gnt_needs_req: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        dma_l1_gnt_o |-> $past(dma_l1_req_i && l1_dma_cfg_i))
        else $error("DMA grant without a configured request.");

    a_sleep_pll: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_SLEEP |-> st.ctrl.pll_en)
        else $error("PLL stopped in sleep.");

    a_sleep_exit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ($past(st.mode) == PMCS_ST_SLEEP && st.mode != PMCS_ST_SLEEP)
        |-> $past(regulator_wake_out_event_i || gpio_wake))
        else $error("Sleep left without a wake event.");

    a_deep_clocks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_DEEP |-> !st.ctrl.core_clk_en && !st.ctrl.sys_clk_en
        && !st.ctrl.pll_en)
        else $error("Deep sleep clocks not stopped.");

    a_deep_stays: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        ($past(st.mode) == PMCS_ST_DEEP && !$past(gpio_wake)) |-> st.mode == PMCS_ST_DEEP)
        else $error("Deep sleep left with no wake.");

    a_async_needs_req: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        async_gnt_o |-> $past(async_req_i))
        else $error("Async grant without a request.");

    a_hib_regs: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_HIBERNATE |-> !st.ctrl.regs_valid && !st.ctrl.core_clk_en
        && !st.ctrl.pll_en)
        else $error("Hibernate state or core clock wrong.");

    a_pads_driven: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode != PMCS_ST_HIBERNATE |-> !st.ctrl.pads_hiz)
        else $error("Pads released outside hibernate.");

    a_hib_stays: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        $past(st.mode) == PMCS_ST_HIBERNATE |-> st.mode == PMCS_ST_HIBERNATE)
        else $error("Hibernate left without a reset.");

    a_reset_wakes_reg: assert property (@(posedge clk_sys_i) disable iff (por_rst_i)
        sys_rst_i |=> regulator_wake_out_o)
        else $error("Reset did not wake the regulator.");

    a_vrctl_kept: assert property (@(posedge clk_sys_i) disable iff (por_rst_i)
        (!$past(cmd_i.vrctl_we) && !$past(sys_rst_i)) |-> $stable(vrctl_o))
        else $error("Regulator control register changed without a write.");

    a_boot_clocks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        st.mode == PMCS_ST_BOOT |-> !st.ctrl.core_clk_en)
        else $error("Core clock running during boot.");

endmodule

//--- tb/pmcs_reg_model.sv
/*
 * Partner model: the core voltage regulator and a GPIO wake source.
 * Assumes the device clock is shared and the wake request is synchronous to it.
 */
`timescale 1ns/1ps

module pmcs_reg_model #(
    parameter int PG_DLY = 8,
    parameter int WAKE_CYC = 1
) (
    // Clock.
    input wire logic clk_sys_i,
    // Regulator side.
    input wire logic regulator_wake_out_i,
    output logic power_good_in_n_o,
    // Wake source side.
    input wire logic wake_req_i,
    output logic gpio_wake_o
);
    int pg_cnt = 0;
    int wake_cnt = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // A low wake output drops the core supply at once; power good comes back only
    // after the supply has ramped for PG_DLY cycles.
    always @(posedge clk_sys_i or negedge regulator_wake_out_i) begin
        if (!regulator_wake_out_i) begin
            pg_cnt <= 0;
        end else if (pg_cnt < PG_DLY) begin
            pg_cnt <= pg_cnt + 1;
        end
    end
    assign power_good_in_n_o = !(regulator_wake_out_i && pg_cnt >= PG_DLY);

    ////////////////////////////////////////////////////////////////////////////////
    // The wake level is held for WAKE_CYC whole cycles, the shortest legal pulse.
    always @(posedge clk_sys_i) begin
        if (wake_req_i) begin
            wake_cnt <= WAKE_CYC;
        end else if (wake_cnt > 0) begin
            wake_cnt <= wake_cnt - 1;
        end
    end
    assign gpio_wake_o = (wake_cnt > 0);
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking testbench of the power-mode clock sequencer.
 * Assumes the design package and the regulator partner model are compiled first.
 */
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module tb_top
    import pmcs_pkg::*;
();
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic por_rst_i = 1'b1;
    logic input_clock_pin_i = 1'b0;
    logic pll_clk_i = 1'b0;
    pmcs_cmd_t cmd_i = '0;
    logic regulator_wake_out_event_i = 1'b0;
    logic dma_l1_req_i = 1'b0;
    logic l1_dma_cfg_i = 1'b0;
    logic async_req_i = 1'b0;
    logic wake_req = 1'b0;
    logic gpio_wake_i, power_good_in_n_i, regulator_wake_out_o;
    logic core_clock_o, sys_clock_o, dma_l1_gnt_o, async_gnt_o;
    pmcs_ctrl_t ctrl_o;
    pmcs_state_t state_o;
    logic [7:0] vrctl_o;
    int num_errors = 0;
    int tests_run = 0;
    int n_core = 0, n_sys = 0, n_in = 0, n_pll = 0;

    always #5 clk_sys_i = ~clk_sys_i;
    always #10 input_clock_pin_i = ~input_clock_pin_i;
    always #2.5 pll_clk_i = ~pll_clk_i;
    always @(posedge core_clock_o) n_core++;
    always @(posedge sys_clock_o) n_sys++;
    always @(posedge input_clock_pin_i) n_in++;
    always @(posedge pll_clk_i) n_pll++;

    pmcs_sequencer u_dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .por_rst_i(por_rst_i),
        .input_clock_pin_i(input_clock_pin_i), .pll_clk_i(pll_clk_i),
        .core_clock_o(core_clock_o), .sys_clock_o(sys_clock_o), .cmd_i(cmd_i),
        .regulator_wake_out_event_i(regulator_wake_out_event_i), .gpio_wake_i(gpio_wake_i),
        .power_good_in_n_i(power_good_in_n_i), .regulator_wake_out_o(regulator_wake_out_o),
        .dma_l1_req_i(dma_l1_req_i), .dma_l1_gnt_o(dma_l1_gnt_o),
        .l1_dma_cfg_i(l1_dma_cfg_i), .async_req_i(async_req_i), .async_gnt_o(async_gnt_o),
        .ctrl_o(ctrl_o), .state_o(state_o), .vrctl_o(vrctl_o)
    );

    pmcs_reg_model u_reg (
        .clk_sys_i(clk_sys_i), .regulator_wake_out_i(regulator_wake_out_o),
        .power_good_in_n_o(power_good_in_n_i), .wake_req_i(wake_req),
        .gpio_wake_o(gpio_wake_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic near(input int a, input int b);
        return a >= b - 1 && a <= b + 1;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk_st(input pmcs_state_t s);
        check("state", {5'h0, state_o}, {5'h0, s});
    endtask

    task automatic chk_ctrl(input logic [7:0] mask, input logic [7:0] exp);
        check("controls", ctrl_o & mask, exp);
    endtask

    task automatic wait_st(input pmcs_state_t s, input int max, output int n);
        n = 0;
        while (state_o !== s && n < max) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic go(input pmcs_req_t m);
        @(posedge clk_sys_i);
        cmd_i.go <= 1'b1;
        cmd_i.mode <= m;
        @(posedge clk_sys_i);
        cmd_i.go <= 1'b0;
        #1;
    endtask

    // A one-cycle wake pulse, from the regulator wake event or from the GPIO source.
    task automatic pulse(input logic gpio);
        @(posedge clk_sys_i);
        if (gpio) wake_req <= 1'b1;
        else regulator_wake_out_event_i <= 1'b1;
        @(posedge clk_sys_i);
        wake_req <= 1'b0;
        regulator_wake_out_event_i <= 1'b0;
        #1;
    endtask

    // Grants are registered, so the answer is looked at one edge after the request.
    task automatic grant(input logic dma, input logic cfg, input logic exp);
        @(posedge clk_sys_i);
        dma_l1_req_i <= dma;
        l1_dma_cfg_i <= cfg;
        async_req_i <= !dma;
        @(posedge clk_sys_i);
        #1;
        check(dma ? "dma grant" : "async grant", {7'h0, dma ? dma_l1_gnt_o : async_gnt_o},
              {7'h0, exp});
        @(posedge clk_sys_i);
        dma_l1_req_i <= 1'b0;
        async_req_i <= 1'b0;
    endtask

    // Counts clock edges over 200 ns against the expected root clock.
    task automatic rate(input logic bypass, input logic core_on, input logic sys_on);
        int c0, s0, r0, e;
        c0 = n_core;
        s0 = n_sys;
        r0 = bypass ? n_in : n_pll;
        cyc(20);
        e = (bypass ? n_in : n_pll) - r0;
        check("core edges", {7'h0, near(n_core - c0, core_on ? e : 0)}, 8'h01);
        check("sys edges", {7'h0, near(n_sys - s0, sys_on ? e : 0)}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        int n;
        chk_st(PMCS_ST_BOOT);
        check("regulator wake", {7'h0, regulator_wake_out_o}, 8'h01);
        check("vrctl reset", vrctl_o, `PMCS_VRCTL_RST);
        n = 0;
        while (power_good_in_n_i !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        chk_st(PMCS_ST_BOOT);
        wait_st(PMCS_ST_FULL_ON, 40, n);
        check("boot length", {7'h0, n >= 15 && n <= 18}, 8'h01);
        chk_st(PMCS_ST_FULL_ON);
        chk_ctrl(8'hF2, 8'hE0);
        rate(1'b0, 1'b1, 1'b1);
    endtask

    task automatic t_sleep();
        int n;
        go(PMCS_REQ_SLEEP);
        chk_st(PMCS_ST_SLEEP);
        chk_ctrl(8'hE2, 8'h60);
        rate(1'b0, 1'b0, 1'b1);
        grant(1'b1, 1'b1, 1'b0);
        go(PMCS_REQ_ACTIVE);
        chk_st(PMCS_ST_SLEEP);
        pulse(1'b0);
        wait_st(PMCS_ST_FULL_ON, 6, n);
        chk_st(PMCS_ST_FULL_ON);
    endtask

    task automatic t_active();
        go(PMCS_REQ_ACTIVE);
        chk_st(PMCS_ST_ACTIVE);
        chk_ctrl(8'hF2, 8'hF0);
        rate(1'b1, 1'b1, 1'b1);
        grant(1'b1, 1'b1, 1'b1);
        grant(1'b1, 1'b0, 1'b0);
        grant(1'b0, 1'b0, 1'b1);
    endtask

    task automatic t_deep();
        int n;
        go(PMCS_REQ_DEEP);
        chk_st(PMCS_ST_DEEP);
        chk_ctrl(8'hE2, 8'h00);
        rate(1'b1, 1'b0, 1'b0);
        grant(1'b0, 1'b0, 1'b0);
        pulse(1'b0);
        cyc(4);
        chk_st(PMCS_ST_DEEP);
        pulse(1'b1);
        wait_st(PMCS_ST_FULL_ON, 8, n);
        chk_st(PMCS_ST_FULL_ON);
    endtask

    task automatic t_hib();
        int n;
        go(PMCS_REQ_HIBERNATE);
        chk_st(PMCS_ST_HIBERNATE);
        chk_ctrl(8'hE3, 8'h02);
        rate(1'b0, 1'b0, 1'b0);
        @(posedge clk_sys_i);
        cmd_i.vrctl_we <= 1'b1;
        cmd_i.vrctl_data <= 8'hA4;
        @(posedge clk_sys_i);
        cmd_i.vrctl_we <= 1'b0;
        #1;
        check("vrctl write", vrctl_o, 8'hA4);
        check("regulator wake", {7'h0, regulator_wake_out_o}, 8'h00);
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        #1;
        check("regulator wake", {7'h0, regulator_wake_out_o}, 8'h01);
        check("vrctl kept", vrctl_o, 8'hA5);
        chk_st(PMCS_ST_BOOT);
        cyc(4);
        chk_st(PMCS_ST_BOOT);
        wait_st(PMCS_ST_FULL_ON, 60, n);
        chk_st(PMCS_ST_FULL_ON);
        chk_ctrl(8'hF2, 8'hE0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        por_rst_i <= 1'b0;
        #1;
        t_boot();
        t_sleep();
        t_active();
        t_deep();
        t_hib();
        stop_test();
    end

    initial begin
        #50000;
        num_errors++;
        stop_test();
    end
endmodule
